// >>> hw/pll_reference_path_control.v
// What this block does
// - Charge pump: hiz, normal, forced up, down
// - Eight current steps, 600 uA to 4.8 mA
// - Normal mode: detector drives pump up/down
// - Config selects differential or two single-ended references
// - All reference inputs disabled after reset
// - Differential receiver off: PLL down or unselected
// - Single-ended buffers off: PLL down, own bit, differential
// - Dual single-ended: manual and automatic switching
// - Manual select by config bit or pin
// - Monitor high while preferred invalid, auto selects the other
// - Status input may drive switch; secondary preferable
// - Deglitch blocks misaligned edges after switch
// - Automatic switching always reverts to preferred
// - 14-bit reference divider split over two fields
// - Reference divide of zero or one divides by one
// - Detector compares divided reference and feedback
// - Reference divider reset: own, shared, sync
// - Feedback divide equals P times B plus A
// - Sync pin reset gated by field, off at reset
// - Counter reset bits hold counters until cleared
`timescale 1ns/10ps
`include "pll_reference_path_control_defines.vh"

module pll_reference_path_control #(
    parameter R_WIDTH  = 14,
    parameter A_WIDTH  = 6,
    parameter B_WIDTH  = 13,
    parameter N_WIDTH  = 20
) (
    input  wire               clk_sys,
    input  wire               arst_n,
    input  wire               pll_power_down,
    input  wire               ref_differential_mode,
    input  wire               diff_ref_enable,
    input  wire               primary_ref_enable,
    input  wire               secondary_ref_enable,
    input  wire               primary_ref_power_down,
    input  wire               secondary_ref_power_down,
    input  wire               manual_select_secondary,
    input  wire               use_select_pin,
    input  wire               reference_select_pin,
    input  wire               auto_switch_enable,
    input  wire               use_status_for_switch,
    input  wire               status_preferred_invalid,
    input  wire               preferred_valid,
    input  wire               prefer_secondary,
    input  wire               deglitch_enable,
    input  wire               reference_input_pin,
    input  wire               primary_reference_input,
    input  wire               secondary_reference_input,
    input  wire               vco_clk_in,
    input  wire [7:0]         r_div_low,
    input  wire [5:0]         r_div_high,
    input  wire [2:0]         prescaler_sel,
    input  wire [A_WIDTH-1:0] a_count,
    input  wire [B_WIDTH-1:0] b_count,
    input  wire               r_counter_reset,
    input  wire               ab_counter_reset,
    input  wire               shared_counter_reset,
    input  wire               sync_n,
    input  wire [1:0]         sync_reset_enable,
    input  wire [2:0]         charge_pump_mode,
    input  wire [2:0]         charge_pump_current_sel,
    output wire               diff_rx_power_down,
    output wire               primary_buf_power_down,
    output wire               secondary_buf_power_down,
    output wire               reference_monitor_output,
    output wire               selected_is_secondary,
    output wire               switch_pending,
    output wire               ref_div_pulse,
    output wire               fb_div_pulse,
    output wire               charge_pump_up,
    output wire               charge_pump_down,
    output wire               charge_pump_hiz,
    output wire [12:0]        charge_pump_current_ua
);

    // Captured configuration, all references off out of reset
    reg                diff_en_ff;
    reg                prim_en_ff;
    reg                sec_en_ff;
    reg [1:0]          sync_en_ff;
    reg [2:0]          pump_mode_ff;
    reg [2:0]          pump_cur_ff;
    reg [R_WIDTH-1:0]  r_div_ff;
    reg [N_WIDTH-1:0]  n_div_ff;
    // Edge history of sampled clocks
    reg                diff_prev_ff;
    reg                prim_prev_ff;
    reg                sec_prev_ff;
    reg                vco_prev_ff;
    // Switchover state
    reg                active_sec_ff;
    reg                pending_ff;
    reg                monitor_ff;
    // Dividers and detector
    reg [R_WIDTH-1:0]  r_cnt_ff;
    reg [N_WIDTH-1:0]  n_cnt_ff;
    reg                r_pulse_ff;
    reg                n_pulse_ff;
    reg                up_ff;
    reg                down_ff;
    reg [12:0]         cur_ua_ff;

    wire               diff_rx_on;
    wire               prim_on;
    wire               sec_on;
    wire               diff_edge;
    wire               prim_edge;
    wire               sec_edge;
    wire               vco_edge;
    wire               manual_sec;
    wire               auto_sec;
    wire               target_sec;
    wire               target_edge;
    wire               ref_edge;
    wire               sync_reset;
    wire               r_reset;
    wire               n_reset;
    wire [R_WIDTH-1:0] r_terminal;
    wire [N_WIDTH-1:0] n_calc;
    wire [N_WIDTH-1:0] n_terminal;
    wire               pump_normal;

    // Prescaler value from its select code
    function [5:0] presc_value;
        input [2:0] sel;
        begin
            case (sel)
                `PRESC_SEL_2:  presc_value = 6'h02;
                `PRESC_SEL_4:  presc_value = 6'h04;
                `PRESC_SEL_8:  presc_value = 6'h08;
                `PRESC_SEL_16: presc_value = 6'h10;
                `PRESC_SEL_32: presc_value = 6'h20;
                default:       presc_value = 6'h02;
            endcase
        end
    endfunction

    // Configuration capture
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            diff_en_ff <= 1'b0;
            prim_en_ff <= 1'b0;
            sec_en_ff  <= 1'b0;
            sync_en_ff <= `SYNC_RST_DISABLED;
            pump_mode_ff <= `PUMP_MODE_RESET;
            pump_cur_ff  <= `PUMP_CUR_RESET;
            r_div_ff   <= `R_DIV_RESET;
            n_div_ff   <= {{(N_WIDTH-1){1'b0}}, 1'b1};
        end else begin
            diff_en_ff <= diff_ref_enable;
            prim_en_ff <= primary_ref_enable;
            sec_en_ff  <= secondary_ref_enable;
            sync_en_ff <= sync_reset_enable;
            pump_mode_ff <= charge_pump_mode;
            pump_cur_ff  <= charge_pump_current_sel;
            r_div_ff   <= {r_div_high, r_div_low};
            n_div_ff   <= n_calc;
        end
    end

    // Receiver and buffer power control
    assign diff_rx_on = diff_en_ff & ref_differential_mode & ~pll_power_down;
    assign diff_rx_power_down = ~diff_rx_on;
    assign prim_on = prim_en_ff & ~primary_ref_power_down & ~ref_differential_mode
                     & ~pll_power_down;
    assign sec_on = sec_en_ff & ~secondary_ref_power_down & ~ref_differential_mode
                    & ~pll_power_down;
    assign primary_buf_power_down   = ~prim_on;
    assign secondary_buf_power_down = ~sec_on;

    // Edge history of the reference and VCO samples
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            diff_prev_ff <= 1'b0;
            prim_prev_ff <= 1'b0;
            sec_prev_ff  <= 1'b0;
            vco_prev_ff  <= 1'b0;
        end else begin
            diff_prev_ff <= reference_input_pin;
            prim_prev_ff <= primary_reference_input;
            sec_prev_ff  <= secondary_reference_input;
            vco_prev_ff  <= vco_clk_in;
        end
    end

    // Rising edges, only from powered inputs
    assign diff_edge = diff_rx_on & reference_input_pin & ~diff_prev_ff;
    assign prim_edge = prim_on & primary_reference_input & ~prim_prev_ff;
    assign sec_edge  = sec_on & secondary_reference_input & ~sec_prev_ff;
    assign vco_edge  = ~pll_power_down & vco_clk_in & ~vco_prev_ff;

    // Selection: manual by bit or pin, automatic is always revertive
    assign manual_sec = use_select_pin ? reference_select_pin
                                       : manual_select_secondary;
    assign auto_sec   = prefer_secondary ^ monitor_ff;
    assign target_sec = auto_switch_enable ? auto_sec : manual_sec;
    assign target_edge = target_sec ? sec_edge : prim_edge;

    // Monitor output tracks preferred reference validity
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            monitor_ff <= 1'b0;
        end else if (use_status_for_switch) begin
            monitor_ff <= status_preferred_invalid;
        end else begin
            monitor_ff <= ~preferred_valid;
        end
    end
    assign reference_monitor_output = monitor_ff;

    // Deglitched switchover, released on the new reference edge
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            active_sec_ff <= 1'b0;
            pending_ff    <= 1'b0;
        end else if (ref_differential_mode) begin
            active_sec_ff <= 1'b0;
            pending_ff    <= 1'b0;
        end else if (target_sec != active_sec_ff) begin
            if (!deglitch_enable) begin
                active_sec_ff <= target_sec;
                pending_ff    <= 1'b0;
            end else if (target_edge) begin
                active_sec_ff <= target_sec;
                pending_ff    <= 1'b0;
            end else begin
                pending_ff    <= 1'b1;
            end
        end else begin
            pending_ff <= 1'b0;
        end
    end
    assign selected_is_secondary = active_sec_ff;
    assign switch_pending = pending_ff;

    // Reference edge into the divider; gated while a switch waits
    assign ref_edge = ref_differential_mode ? diff_edge :
                      (pending_ff | (target_sec != active_sec_ff)) ?
                      (deglitch_enable ? 1'b0 : target_edge) :
                      (active_sec_ff ? sec_edge : prim_edge);

    // Counter resets from bits and the sync pin
    assign sync_reset = (sync_en_ff != `SYNC_RST_DISABLED) & ~sync_n;
    assign r_reset = r_counter_reset | shared_counter_reset | sync_reset;
    assign n_reset = ab_counter_reset | shared_counter_reset | sync_reset;

    // Reference divider, zero and one both divide by one
    assign r_terminal = (r_div_ff == {R_WIDTH{1'b0}}) ? {R_WIDTH{1'b0}}
                        : r_div_ff - {{(R_WIDTH-1){1'b0}}, 1'b1};

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r_cnt_ff   <= {R_WIDTH{1'b0}};
            r_pulse_ff <= 1'b0;
        end else if (r_reset) begin
            r_cnt_ff   <= {R_WIDTH{1'b0}};
            r_pulse_ff <= 1'b0;
        end else if (ref_edge) begin
            if (r_cnt_ff >= r_terminal) begin
                r_cnt_ff   <= {R_WIDTH{1'b0}};
                r_pulse_ff <= 1'b1;
            end else begin
                r_cnt_ff   <= r_cnt_ff + {{(R_WIDTH-1){1'b0}}, 1'b1};
                r_pulse_ff <= 1'b0;
            end
        end else begin
            r_pulse_ff <= 1'b0;
        end
    end
    assign ref_div_pulse = r_pulse_ff;

    // Feedback divide value P*B+A, zero treated as one
    assign n_calc = {{(N_WIDTH-6){1'b0}}, presc_value(prescaler_sel)}
                    * {{(N_WIDTH-B_WIDTH){1'b0}}, b_count}
                    + {{(N_WIDTH-A_WIDTH){1'b0}}, a_count};
    assign n_terminal = (n_div_ff == {N_WIDTH{1'b0}}) ? {N_WIDTH{1'b0}}
                        : n_div_ff - {{(N_WIDTH-1){1'b0}}, 1'b1};

    // Feedback divider on VCO edges
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            n_cnt_ff   <= {N_WIDTH{1'b0}};
            n_pulse_ff <= 1'b0;
        end else if (n_reset) begin
            n_cnt_ff   <= {N_WIDTH{1'b0}};
            n_pulse_ff <= 1'b0;
        end else if (vco_edge) begin
            if (n_cnt_ff >= n_terminal) begin
                n_cnt_ff   <= {N_WIDTH{1'b0}};
                n_pulse_ff <= 1'b1;
            end else begin
                n_cnt_ff   <= n_cnt_ff + {{(N_WIDTH-1){1'b0}}, 1'b1};
                n_pulse_ff <= 1'b0;
            end
        end else begin
            n_pulse_ff <= 1'b0;
        end
    end
    assign fb_div_pulse = n_pulse_ff;

    // Phase frequency detector: divided reference against feedback
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            up_ff   <= 1'b0;
            down_ff <= 1'b0;
        end else if (!pump_normal) begin
            up_ff   <= 1'b0;
            down_ff <= 1'b0;
        end else begin
            case ({up_ff | r_pulse_ff, down_ff | n_pulse_ff})
                2'b11: begin
                    up_ff   <= 1'b0;
                    down_ff <= 1'b0;
                end
                2'b10: begin
                    up_ff   <= 1'b1;
                    down_ff <= 1'b0;
                end
                2'b01: begin
                    up_ff   <= 1'b0;
                    down_ff <= 1'b1;
                end
                default: begin
                    up_ff   <= 1'b0;
                    down_ff <= 1'b0;
                end
            endcase
        end
    end

    // Charge pump mode outputs
    assign pump_normal = (pump_mode_ff == `PUMP_MODE_NORMAL) & ~pll_power_down;
    assign charge_pump_up   = ~pll_power_down & ((pump_mode_ff == `PUMP_MODE_UP)
                              | (pump_normal & up_ff));
    assign charge_pump_down = ~pll_power_down & ((pump_mode_ff == `PUMP_MODE_DOWN)
                              | (pump_normal & down_ff));
    assign charge_pump_hiz  = ~charge_pump_up & ~charge_pump_down;

    // Charge pump current in microamps, 600 per step
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cur_ua_ff <= `PUMP_STEP_UA;
        end else begin
            cur_ua_ff <= {9'h000, {1'b0, pump_cur_ff} + 4'h1} * `PUMP_STEP_UA;
        end
    end
    assign charge_pump_current_ua = cur_ua_ff;

endmodule

// >>> hw/pll_reference_path_control_defines.vh
`ifndef PLL_REFERENCE_PATH_CONTROL_DEFINES_VH
`define PLL_REFERENCE_PATH_CONTROL_DEFINES_VH

// Charge pump mode field encodings
`define PUMP_MODE_HIZ        3'h0
`define PUMP_MODE_UP         3'h1
`define PUMP_MODE_DOWN       3'h2
`define PUMP_MODE_NORMAL     3'h3

// Charge pump current step, microamps per step
`define PUMP_STEP_UA         13'h0258

// Prescaler select encodings and values
`define PRESC_SEL_2          3'h0
`define PRESC_SEL_4          3'h1
`define PRESC_SEL_8          3'h2
`define PRESC_SEL_16         3'h3
`define PRESC_SEL_32         3'h4

// Sync pin reset enable field
`define SYNC_RST_DISABLED    2'h0

// Reset values of captured configuration
`define PUMP_MODE_RESET      3'h0
`define PUMP_CUR_RESET       3'h0
`define R_DIV_RESET          14'h0001

`endif

// >>> test/pll_ref_chk_sva.sv
`timescale 1ns/10ps
`include "pll_reference_path_control_defines.vh"
module pll_ref_chk (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        pll_power_down,
    input wire        ref_differential_mode,
    input wire        primary_ref_power_down,
    input wire        secondary_ref_power_down,
    input wire        use_status_for_switch,
    input wire        status_preferred_invalid,
    input wire        preferred_valid,
    input wire        r_counter_reset,
    input wire        shared_counter_reset,
    input wire [2:0]  charge_pump_mode,
    input wire [2:0]  charge_pump_current_sel,
    input wire        diff_rx_power_down,
    input wire        primary_buf_power_down,
    input wire        secondary_buf_power_down,
    input wire        reference_monitor_output,
    input wire        selected_is_secondary,
    input wire        switch_pending,
    input wire        ref_div_pulse,
    input wire        charge_pump_up,
    input wire        charge_pump_down,
    input wire        charge_pump_hiz,
    input wire [12:0] charge_pump_current_ua
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_diff_rx_off: assert property (
        (pll_power_down || !ref_differential_mode) |-> diff_rx_power_down)
        else $error("diff rx on");
    a_prim_buf_off: assert property (
        (pll_power_down || ref_differential_mode || primary_ref_power_down)
        |-> primary_buf_power_down) else $error("primary buffer on");
    a_sec_buf_off: assert property (
        (pll_power_down || ref_differential_mode || secondary_ref_power_down)
        |-> secondary_buf_power_down) else $error("secondary buffer on");
    a_pump_hiz_mode: assert property (
        charge_pump_mode == `PUMP_MODE_HIZ |=> charge_pump_hiz && !charge_pump_up
        && !charge_pump_down) else $error("pump not idle");
    a_pump_forced_up: assert property (
        charge_pump_mode == `PUMP_MODE_UP ##1 !pll_power_down |-> charge_pump_up
        && !charge_pump_down) else $error("pump not up");
    a_pump_exclusive: assert property (
        !(charge_pump_up && charge_pump_down) && !(charge_pump_hiz && charge_pump_up))
        else $error("pump outputs clash");
    a_current_step: assert property (
        1'b1 |=> charge_pump_current_ua == ({10'h000, $past(charge_pump_current_sel, 2)}
        + 13'h0001) * `PUMP_STEP_UA) else $error("pump current wrong");
    a_monitor_follow: assert property (
        1'b1 |=> reference_monitor_output == ($past(use_status_for_switch) ?
        $past(status_preferred_invalid) : !$past(preferred_valid))) else $error("monitor wrong");
    a_pending_hold: assert property (
        switch_pending ##1 switch_pending |-> $stable(selected_is_secondary))
        else $error("switch while pending");
    a_ref_reset_hold: assert property (
        (r_counter_reset || shared_counter_reset) [*3] |-> !ref_div_pulse)
        else $error("pulse in reset");
    a_ref_pulse_single: assert property (
        ref_div_pulse |=> !ref_div_pulse) else $error("pulse too long");
endmodule

bind pll_reference_path_control pll_ref_chk i_pll_ref_chk (
    .clk_sys, .arst_n, .pll_power_down, .ref_differential_mode, .primary_ref_power_down,
    .secondary_ref_power_down, .use_status_for_switch, .status_preferred_invalid,
    .preferred_valid, .r_counter_reset, .shared_counter_reset, .charge_pump_mode,
    .charge_pump_current_sel, .diff_rx_power_down, .primary_buf_power_down,
    .secondary_buf_power_down, .reference_monitor_output, .selected_is_secondary,
    .switch_pending, .ref_div_pulse, .charge_pump_up, .charge_pump_down, .charge_pump_hiz,
    .charge_pump_current_ua);

// >>> test/ref_clock_source.sv
`timescale 1ns/10ps
module ref_clock_source (
    input  wire       clk_sys,
    input  wire       run,
    input  wire [7:0] half,
    output logic      ref_out
);
    logic [7:0] cnt_ff;

    // Square wave while running, parked low when stopped
    always @(posedge clk_sys) begin
        if (!run) begin
            cnt_ff  <= 8'h00;
            ref_out <= 1'b0;
        end else if (cnt_ff == half - 8'h01) begin
            cnt_ff  <= 8'h00;
            ref_out <= !ref_out;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
`include "pll_reference_path_control_defines.vh"
module testbench;
    logic        clk_sys = 1'b0, arst_n = 1'b0, pll_power_down = 1'b0, deglitch_enable = 1'b0;
    logic        ref_differential_mode = 1'b0, diff_ref_enable = 1'b0, sync_n = 1'b1;
    logic        primary_ref_enable = 1'b0, secondary_ref_enable = 1'b0, fb_sel = 1'b0;
    logic        primary_ref_power_down = 1'b0, secondary_ref_power_down = 1'b0;
    logic        manual_select_secondary = 1'b0, use_select_pin = 1'b0, prev_in = 1'b0;
    logic        reference_select_pin = 1'b0, auto_switch_enable = 1'b0, prefer_secondary = 1'b0;
    logic        use_status_for_switch = 1'b0, status_preferred_invalid = 1'b0;
    logic        preferred_valid = 1'b1, run_p = 1'b0, run_s = 1'b0, run_v = 1'b0;
    logic        r_counter_reset = 1'b0, ab_counter_reset = 1'b0, shared_counter_reset = 1'b0;
    logic [7:0]  r_div_low = 8'h01;
    logic [5:0]  r_div_high = 6'h00, a_count = 6'h00;
    logic [2:0]  prescaler_sel = 3'h0, charge_pump_mode = 3'h0, charge_pump_current_sel = 3'h0;
    logic [12:0] b_count = 13'h0001;
    logic [1:0]  sync_reset_enable = 2'h0;
    logic [31:0] seed = 32'h9d8fa256;
    logic        cnt_clr = 1'b0;
    logic [2:0]  m_tab [4] = '{`PUMP_MODE_HIZ, `PUMP_MODE_UP, `PUMP_MODE_DOWN, 3'h7};
    integer      r_tab [4] = '{0, 1, 3, 256};
    integer      mismatches = 0, compares = 0, edges = 0, pulses = 0, i, p;
    wire         primary_reference_input, secondary_reference_input, vco_clk_in;
    wire         diff_rx_power_down, primary_buf_power_down, secondary_buf_power_down;
    wire         reference_monitor_output, selected_is_secondary, switch_pending, fb_div_pulse;
    wire         ref_div_pulse, charge_pump_up, charge_pump_down, charge_pump_hiz;
    wire [12:0]  charge_pump_current_ua;
    wire         reference_input_pin = primary_reference_input;

    always #2 clk_sys = !clk_sys;

    ref_clock_source i_src_p (.clk_sys, .run(run_p), .half(8'h02),
                              .ref_out(primary_reference_input));
    ref_clock_source i_src_s (.clk_sys, .run(run_s), .half(8'h03),
                              .ref_out(secondary_reference_input));
    ref_clock_source i_src_v (.clk_sys, .run(run_v), .half(8'h02), .ref_out(vco_clk_in));

    pll_reference_path_control i_pll_reference_path_control (
        .clk_sys, .arst_n, .pll_power_down, .ref_differential_mode, .diff_ref_enable,
        .primary_ref_enable, .secondary_ref_enable, .primary_ref_power_down,
        .secondary_ref_power_down, .manual_select_secondary, .use_select_pin,
        .reference_select_pin, .auto_switch_enable, .use_status_for_switch,
        .status_preferred_invalid, .preferred_valid, .prefer_secondary, .deglitch_enable,
        .reference_input_pin, .primary_reference_input, .secondary_reference_input, .vco_clk_in,
        .r_div_low, .r_div_high, .prescaler_sel, .a_count, .b_count, .r_counter_reset,
        .ab_counter_reset, .shared_counter_reset, .sync_n, .sync_reset_enable, .charge_pump_mode,
        .charge_pump_current_sel, .diff_rx_power_down, .primary_buf_power_down,
        .secondary_buf_power_down, .reference_monitor_output, .selected_is_secondary,
        .switch_pending, .ref_div_pulse, .fb_div_pulse, .charge_pump_up, .charge_pump_down,
        .charge_pump_hiz, .charge_pump_current_ua);

    // Reference model input: edges seen and divider pulses
    always @(posedge clk_sys) begin
        prev_in <= fb_sel ? vco_clk_in : primary_reference_input;
        if (cnt_clr) begin
            edges  <= 0;
            pulses <= 0;
        end else begin
            if ((fb_sel ? vco_clk_in : primary_reference_input) && !prev_in) edges <= edges + 1;
            if (fb_sel ? fb_div_pulse : ref_div_pulse) pulses <= pulses + 1;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Reset a divider, run its clock, compare pulses with edges / divide
    task measure(input logic fb, input integer div, input integer kind);
        @(posedge clk_sys);
        fb_sel <= fb;
        tick(3);
        cnt_clr <= 1'b1;
        r_counter_reset <= (kind == 0) && !fb;
        ab_counter_reset <= (kind == 0) && fb;
        shared_counter_reset <= (kind == 1);
        sync_n <= (kind != 2);
        tick(4);
        {r_counter_reset, ab_counter_reset, shared_counter_reset, sync_n} <= 4'h1;
        cnt_clr <= 1'b0;
        tick(2);
        run_p <= !fb;
        run_v <= fb;
        tick(8 * (div < 2 ? 1 : div) + 2);
        {run_p, run_v} <= 2'h0;
        tick(6);
        check("div_pulses", pulses, edges / (div < 2 ? 1 : div));
    endtask

    task sw_step(input logic exp_sel, input logic exp_mon);
        tick(12);
        check("selected", selected_is_secondary, exp_sel);
        check("monitor", reference_monitor_output, exp_mon);
    endtask

    task finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches = mismatches + 1;
        finish_test;
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        tick(1);
        check("prim_pd", primary_buf_power_down, 1'b1);
        check("hiz", charge_pump_hiz, 1'b1);
        for (i = 0; i < 24; i++) begin
            seed = xs(seed);
            @(posedge clk_sys);
            {pll_power_down, ref_differential_mode, primary_ref_power_down,
             secondary_ref_power_down, diff_ref_enable, primary_ref_enable,
             secondary_ref_enable} <= seed[6:0];
            tick(2);
            check("diff_pd", diff_rx_power_down,
                  pll_power_down | !ref_differential_mode | !diff_ref_enable);
            check("prim_pd", primary_buf_power_down,
                  pll_power_down | ref_differential_mode | primary_ref_power_down
                  | !primary_ref_enable);
            check("sec_pd", secondary_buf_power_down,
                  pll_power_down | ref_differential_mode | secondary_ref_power_down
                  | !secondary_ref_enable);
        end
        @(posedge clk_sys);
        {pll_power_down, ref_differential_mode, primary_ref_power_down} <= 3'h0;
        {secondary_ref_power_down, diff_ref_enable, primary_ref_enable} <= 3'h3;
        secondary_ref_enable <= 1'b1;
        {sync_reset_enable, a_count, b_count} <= {2'h1, 6'h01, 13'h0002};
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            charge_pump_current_sel <= i[2:0];
            tick(2);
            check("current", charge_pump_current_ua, (i + 1) * 600);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            charge_pump_mode <= m_tab[i];
            tick(2);
            check("up", charge_pump_up, m_tab[i] == `PUMP_MODE_UP);
            check("down", charge_pump_down, m_tab[i] == `PUMP_MODE_DOWN);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {r_div_high, r_div_low} <= 14'(r_tab[i]);
            measure(1'b0, r_tab[i], i % 3);
        end
        for (i = 0; i < 6; i++) begin
            p = (i < 5) ? (2 << i) : 2;
            @(posedge clk_sys);
            prescaler_sel <= i[2:0];
            measure(1'b1, 2 * p + 1, i % 3);
        end
        @(posedge clk_sys);
        {r_div_high, r_div_low, shared_counter_reset} <= {14'h0001, 1'b1};
        charge_pump_mode <= `PUMP_MODE_NORMAL;
        tick(4);
        {shared_counter_reset, run_p} <= 2'h1;
        tick(16);
        check("up", {charge_pump_up, charge_pump_down}, 2'h2);
        {run_p, run_v} <= 2'h1;
        tick(80);
        check("down", {charge_pump_up, charge_pump_down}, 2'h1);
        {run_p, run_s, run_v, manual_select_secondary} <= 4'hd;
        sw_step(1'b1, 1'b0);
        {use_select_pin, run_s} <= 2'h2;
        sw_step(1'b0, 1'b0);
        {deglitch_enable, reference_select_pin} <= 2'h3;
        sw_step(1'b0, 1'b0);
        check("pending", switch_pending, 1'b1);
        run_s <= 1'b1;
        sw_step(1'b1, 1'b0);
        check("pending", switch_pending, 1'b0);
        {auto_switch_enable, use_select_pin, preferred_valid} <= 3'h4;
        sw_step(1'b1, 1'b1);
        preferred_valid <= 1'b1;
        sw_step(1'b0, 1'b0);
        prefer_secondary <= 1'b1;
        sw_step(1'b1, 1'b0);
        {use_status_for_switch, status_preferred_invalid} <= 2'h3;
        sw_step(1'b0, 1'b1);
        finish_test;
    end
endmodule
